/* core/rbc_pkg.sv */
// Purpose: shared constants for the reset and boot controller
// Assumes: single 50 MHz clock, byte-wide boot memory reads
// Notes: boot codes are sampled at device reset release
package rbc_pkg;
   localparam logic [1:0] BOOT_NONE = 2'h0;
   localparam logic [1:0] BOOT_HOST = 2'h1;
   localparam logic [1:0] BOOT_ROM = 2'h2;
   localparam int unsigned ROM_BYTES = 1024;
   localparam int unsigned ROM_WORDS = ROM_BYTES / 4;
   localparam logic [9:0] ROM_LAST_BYTE = 10'h3FF;
   localparam logic [31:0] ROM_SRC_BASE = 32'h0000_0000;
   localparam logic [31:0] COPY_DST_BASE = 32'h0000_0000;
   localparam logic [31:0] CORE_START_PC = 32'h0000_0000;
   localparam logic [5:0] PWRD_CLOCK_HALT = 6'h1A;
   localparam logic [5:0] PWRD_OSC_STOP = 6'h1C;
   localparam logic [1:0] VARIANT_CODE = 2'h1; // arbitrary value
   typedef enum logic [3:0] {
      RBC_IDLE = 4'h1,
      RBC_HOST = 4'h2,
      RBC_COPY = 4'h4,
      RBC_RUN = 4'h8
   } rbc_state_e;
endpackage

/* core/rbc_reset_boot.sv */
// Purpose: boot selection, core stall, ROM copy, emulation and power-down masking
// Assumes: boot_mode and port_select stable around reset release
// Notes: test reset and emulation pins are async and are synchronised here
`timescale 1ns/10ps
// Functional notes
// - low device reset holds reset state; release starts configured boot
// - host boot stalls only the core; peripherals run
// - port_select 0 routes host to host port, 1 to PCI
// - host interrupt bit in host boot releases stall, core starts at 0
// - the boot-ending host interrupt is not latched as pending
// - host interrupt bit releases stall only under host boot
// - host may write and read all memory during host boot
// - core clears the interrupt bit; while set no new interrupts arrive
// - ROM boot copies 1K bytes from first select space to 0, stalled
// - consecutive bytes are packed into 32-bit words by endian setting
// - copy is one block; stall released only after it completes
// - no boot starts the core at 0 immediately, no stall or copy
// - attached emulator masks power-down until emulator reset or removal
// - in deep sleep emulation runs idle, PC writes fail, reset exits
// - only device reset release is needed; test reset may stay low
// - id variant is valid only after device reset release
// - test reset rising edge after release latches emulation pins
module rbc_reset_boot (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic [1:0] boot_mode,
   input wire logic port_select,
   input wire logic big_endian,
   input wire logic test_reset_b,
   input wire logic emulation_config_pin_high,
   input wire logic emulation_config_pin_low,
   input wire logic emu_attached,
   input wire logic emu_reset,
   input wire logic host_set_int,
   input wire logic core_clear_int,
   input wire logic [5:0] pwrd_req,
   input wire logic emu_exec_cmd,
   input wire logic emu_pc_write,
   output logic core_stall,
   output logic [31:0] core_start_pc,
   output logic periph_run,
   output logic host_port_sel,
   output logic pci_sel,
   output logic host_mem_access,
   output logic host_to_core_interrupt_bit,
   output logic core_int_pending,
   output logic rom_rd_req,
   output logic [31:0] rom_rd_addr,
   input wire logic [7:0] rom_rd_data,
   input wire logic rom_rd_valid,
   output logic mem_wr_en,
   output logic [31:0] mem_wr_addr,
   output logic [31:0] mem_wr_data,
   output logic copy_done,
   output logic [5:0] pwrd_eff,
   output logic emu_spin_idle,
   output logic pc_write_fail,
   output logic [1:0] emu_cfg,
   output logic emu_cfg_valid,
   output logic [1:0] id_variant
);
   import rbc_pkg::*;

   rbc_state_e state;
   logic [1:0] boot_sel;
   logic released;
   logic [9:0] byte_cnt;
   logic [31:0] pack;
   logic [1:0] trst_sync;
   logic trst_prev;
   logic [1:0] emuh_sync;
   logic [1:0] emul_sync;
   logic deep_sleep;
   logic emu_mask;

   // byte lane of a copy byte within its word, per endian setting
   function automatic logic [1:0] lane(input logic [1:0] idx, input logic be);
      lane = be ? ~idx : idx;
   endfunction

   // catch boot method on the first edge after release, hold till reset
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         released <= 1'b0;
         boot_sel <= BOOT_NONE;
      end else if (!released) begin
         released <= 1'b1;
         boot_sel <= boot_mode;
      end
   end

   // boot sequencer
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         state <= RBC_IDLE;
      end else begin
         case (state)
            RBC_IDLE: begin
               // decide from the caught copy, never the live pins, so a strap
               // that moves after release cannot switch the boot under way
               if (!released) begin
                  state <= RBC_IDLE;
               end else if (boot_sel == BOOT_HOST) begin
                  state <= RBC_HOST;
               end else if (boot_sel == BOOT_ROM) begin
                  state <= RBC_COPY;
               end else begin
                  state <= RBC_RUN;
               end
            end
            RBC_HOST: begin
               // only host boot lets the interrupt bit end the stall
               if (host_set_int && boot_sel == BOOT_HOST) begin
                  state <= RBC_RUN;
               end
            end
            RBC_COPY: begin
               if (rom_rd_valid && byte_cnt == ROM_LAST_BYTE) begin
                  state <= RBC_RUN;
               end
            end
            RBC_RUN: state <= RBC_RUN;
            default: state <= RBC_IDLE;
         endcase
      end
   end

   // stall held while idle (reset state), host boot or copy
   assign core_stall = (state != RBC_RUN);
   assign core_start_pc = CORE_START_PC;
   assign periph_run = released;
   assign host_port_sel = (state == RBC_HOST) && !port_select;
   assign pci_sel = (state == RBC_HOST) && port_select;
   assign host_mem_access = (state == RBC_HOST);
   assign rom_rd_req = (state == RBC_COPY);

   // host interrupt bit: set wins over clear; stalled set not pended
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         host_to_core_interrupt_bit <= 1'b0;
         core_int_pending <= 1'b0;
      end else begin
         if (host_set_int) begin
            host_to_core_interrupt_bit <= 1'b1;
         end else if (core_clear_int) begin
            host_to_core_interrupt_bit <= 1'b0;
         end
         // a set while bit still high is dropped; stalled core never pends
         if (host_set_int && !host_to_core_interrupt_bit && !core_stall) begin
            core_int_pending <= 1'b1;
         end else if (core_clear_int) begin
            core_int_pending <= 1'b0;
         end
      end
   end

   // single-frame byte copy packed into words
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         byte_cnt <= 10'h000;
         pack <= 32'h0000_0000;
         mem_wr_en <= 1'b0;
         mem_wr_addr <= 32'h0000_0000;
         mem_wr_data <= 32'h0000_0000;
         copy_done <= 1'b0;
      end else begin
         mem_wr_en <= 1'b0;
         if (state == RBC_COPY && rom_rd_valid) begin
            byte_cnt <= byte_cnt + 10'h001;
            pack[8*lane(byte_cnt[1:0], big_endian) +: 8] <= rom_rd_data;
            if (byte_cnt[1:0] == 2'h3) begin
               mem_wr_en <= 1'b1;
               mem_wr_addr <= COPY_DST_BASE + {22'h0, byte_cnt[9:2], 2'h0};
               mem_wr_data <= pack;
               mem_wr_data[8*lane(2'h3, big_endian) +: 8] <= rom_rd_data;
            end
            if (byte_cnt == ROM_LAST_BYTE) begin
               copy_done <= 1'b1;
            end
         end
      end
   end
   assign rom_rd_addr = ROM_SRC_BASE + {22'h0, byte_cnt};

   // two-stage synchronisers for test reset and emulation pins
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         trst_sync <= 2'h0;
         emuh_sync <= 2'h0;
         emul_sync <= 2'h0;
      end else begin
         trst_sync <= {trst_sync[0], test_reset_b};
         emuh_sync <= {emuh_sync[0], emulation_config_pin_high};
         emul_sync <= {emul_sync[0], emulation_config_pin_low};
      end
   end

   // test reset rising edge after release latches emulation config
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         trst_prev <= 1'b0;
         emu_cfg <= 2'h0;
         emu_cfg_valid <= 1'b0;
      end else begin
         trst_prev <= trst_sync[1];
         if (!trst_sync[1]) begin
            emu_cfg_valid <= 1'b0;
         end else if (released && !trst_prev) begin
            emu_cfg <= {emuh_sync[1], emul_sync[1]};
            emu_cfg_valid <= 1'b1;
         end
      end
   end

   // variant field reads zero until device reset is released
   assign id_variant = released ? VARIANT_CODE : 2'h0;

   // mask is live: it drops in the cycle the emulator is reset or pulled
   assign emu_mask = emu_attached && !emu_reset;

   // emulator masking of power-down; deep sleep stuck until device reset
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         deep_sleep <= 1'b0;
         pwrd_eff <= 6'h00;
      end else begin
         if (!deep_sleep) begin
            pwrd_eff <= emu_mask ? 6'h00 : pwrd_req;
            if (!emu_mask &&
                (pwrd_req == PWRD_CLOCK_HALT || pwrd_req == PWRD_OSC_STOP)) begin
               deep_sleep <= 1'b1;
            end
         end
      end
   end

   assign emu_spin_idle = deep_sleep && emu_exec_cmd;
   assign pc_write_fail = deep_sleep && emu_pc_write;

   a_rom_stall_held: assert property (@(posedge mclk) disable iff (!rst_b)
      state == RBC_COPY |-> core_stall) else $error("core ran during copy");
   a_host_release: assert property (@(posedge mclk) disable iff (!rst_b)
      state == RBC_HOST && host_set_int |=> !core_stall) else $error("no release");
   a_no_pend_stall: assert property (@(posedge mclk) disable iff (!rst_b)
      core_stall && !core_int_pending |=> !core_int_pending) else $error("pended");
   a_port_route: assert property (@(posedge mclk) disable iff (!rst_b)
      state == RBC_HOST |-> pci_sel == port_select) else $error("bad port");
   a_noboot_run: assert property (@(posedge mclk) disable iff (!rst_b)
      state == RBC_IDLE && released && boot_sel != BOOT_HOST && boot_sel != BOOT_ROM
      |=> !core_stall)
      else $error("no-boot stalled");
   a_copy_before_run: assert property (@(posedge mclk) disable iff (!rst_b)
      $fell(core_stall) && boot_sel == BOOT_ROM |-> copy_done) else $error("early");
   a_emu_masks: assert property (@(posedge mclk) disable iff (!rst_b)
      emu_attached && !emu_reset && !deep_sleep |=> pwrd_eff == 6'h00)
      else $error("not masked");
   a_sleep_sticky: assert property (@(posedge mclk) disable iff (!rst_b)
      deep_sleep |=> deep_sleep) else $error("sleep left");
   a_variant_gate: assert property (@(posedge mclk) disable iff (!rst_b)
      !released |-> id_variant == 2'h0) else $error("variant early");

   // copy end: last byte taken, then write pulse, done flag and release together
   sequence s_copy_last;
      state == RBC_COPY && rom_rd_valid && byte_cnt == ROM_LAST_BYTE;
   endsequence
   sequence s_copy_free;
      !core_stall && copy_done && mem_wr_en;
   endsequence
   a_copy_release: assert property (@(posedge mclk) disable iff (!rst_b)
      s_copy_last |=> s_copy_free) else $error("copy end not seen");

   // every fourth byte of the copy gives one word write, one cycle later
   sequence s_word_byte;
      state == RBC_COPY && rom_rd_valid && byte_cnt[1:0] == 2'h3;
   endsequence
   a_word_write: assert property (@(posedge mclk) disable iff (!rst_b)
      s_word_byte |=> mem_wr_en) else $error("word not written");

   // no write strobe without a byte taken in the copy just before
   a_no_stray_write: assert property (@(posedge mclk) disable iff (!rst_b)
      !(state == RBC_COPY && rom_rd_valid) |=> !mem_wr_en) else $error("stray write");

   // done flag stays up until the next device reset
   a_done_sticky: assert property (@(posedge mclk) disable iff (!rst_b)
      copy_done |=> copy_done) else $error("done dropped");

   // the host bit during a copy in flight must leave the core stalled
   a_int_no_release: assert property (@(posedge mclk) disable iff (!rst_b)
      state == RBC_COPY && host_set_int && !(rom_rd_valid && byte_cnt == ROM_LAST_BYTE)
      |=> core_stall) else $error("bit freed copy");

   // a set that meets a still-high bit never makes a new pending event
   a_bit_blocks: assert property (@(posedge mclk) disable iff (!rst_b)
      host_to_core_interrupt_bit && !core_int_pending |=> !core_int_pending)
      else $error("set through high bit");

   // pending may only rise out of a cycle in which the core already ran
   a_pend_needs_run: assert property (@(posedge mclk) disable iff (!rst_b)
      $rose(core_int_pending) |-> !$past(core_stall)) else $error("stalled set pended");

   // host boot keeps the core stalled with peripherals and memory open
   a_host_open: assert property (@(posedge mclk) disable iff (!rst_b)
      state == RBC_HOST |-> periph_run && host_mem_access && core_stall)
      else $error("host boot not open");

   // the two host paths are never selected together
   a_route_single: assert property (@(posedge mclk) disable iff (!rst_b)
      !(host_port_sel && pci_sel)) else $error("both host paths");

   // no boot means no copy request and no host window at all
   a_none_quiet: assert property (@(posedge mclk) disable iff (!rst_b)
      released && boot_sel == BOOT_NONE |-> !rom_rd_req && !host_mem_access)
      else $error("no-boot not quiet");

   // a running core always fetches from the start address
   a_start_zero: assert property (@(posedge mclk) disable iff (!rst_b)
      !core_stall |-> core_start_pc == CORE_START_PC) else $error("bad start");

   // boot choice stays put once caught, whatever the pins do later
   a_boot_held: assert property (@(posedge mclk) disable iff (!rst_b)
      released |=> $stable(boot_sel)) else $error("boot choice moved");

   // emulation pins latch on the synchronised test reset rise
   sequence s_trst_rise;
      released && trst_sync[1] && !trst_prev;
   endsequence
   a_cfg_latch: assert property (@(posedge mclk) disable iff (!rst_b)
      s_trst_rise |=> emu_cfg_valid) else $error("config not latched");

   // a held test reset keeps the emulation config invalid
   a_trst_hold: assert property (@(posedge mclk) disable iff (!rst_b)
      !trst_sync[1] |=> !emu_cfg_valid) else $error("config valid in test reset");

   // deep sleep turns run or step into idle and every PC write into a fail
   a_sleep_blocks: assert property (@(posedge mclk) disable iff (!rst_b)
      deep_sleep && emu_exec_cmd && emu_pc_write |-> emu_spin_idle && pc_write_fail)
      else $error("command escaped sleep");

   // the field seen in deep sleep is frozen; only a device reset moves it
   a_sleep_freeze: assert property (@(posedge mclk) disable iff (!rst_b)
      deep_sleep |=> $stable(pwrd_eff)) else $error("sleep field moved");
endmodule

/* tb/rbc_rom_model.sv */
// Purpose: boot memory model answering byte reads during the image copy
// Assumes: one read outstanding, address held until valid is seen
// Notes: idle data toggles every cycle so a stale byte never matches
`timescale 1ns/10ps
module rbc_rom_model (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic [1:0] lat,
   input wire logic rom_rd_req,
   input wire logic [31:0] rom_rd_addr,
   output logic [7:0] rom_rd_data,
   output logic rom_rd_valid
);
   int cnt;
   // one byte per request after lat + 1 idle cycles, content tied to address
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rom_rd_valid <= 1'b0;
         rom_rd_data <= 8'h00;
         cnt <= 0;
      end else if (rom_rd_valid || !rom_rd_req) begin
         rom_rd_valid <= 1'b0;
         rom_rd_data <= ~rom_rd_data; // released bus keeps moving
         cnt <= 0;
      end else if (cnt >= lat) begin
         rom_rd_valid <= 1'b1;
         rom_rd_data <= rom_rd_addr[7:0] ^ 8'h5A;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule

/* tb/tb_top.sv */
// Purpose: self-checking bench for the reset and boot controller
// Assumes: inputs change at falling edges, outputs are read there
// Notes: rom bytes are address xor 5A, made by the partner model
`timescale 1ns/10ps
module tb_top;
   import rbc_pkg::*;
   logic mclk = 1'b0, rst_b = 1'b0, port_select = 1'b0, big_endian = 1'b0;
   logic test_reset_b = 1'b0, emulation_config_pin_high = 1'b0, emulation_config_pin_low = 1'b0;
   logic emu_attached = 1'b0, emu_reset = 1'b0, host_set_int = 1'b0, core_clear_int = 1'b0;
   logic emu_exec_cmd = 1'b0, emu_pc_write = 1'b0, core_stall, periph_run, host_port_sel;
   logic pci_sel, host_mem_access, host_to_core_interrupt_bit, core_int_pending, rom_rd_req;
   logic rom_rd_valid, mem_wr_en, copy_done, emu_spin_idle, pc_write_fail, emu_cfg_valid;
   logic [1:0] boot_mode = 2'h0, lat = 2'h0, emu_cfg, id_variant;
   logic [5:0] pwrd_req = 6'h00, pwrd_eff;
   logic [7:0] rom_rd_data;
   logic [31:0] core_start_pc, rom_rd_addr, mem_wr_addr, mem_wr_data;
   int fails = 0;
   int checks_done = 0;
   // 50 MHz clock
   always #10 mclk = ~mclk;
   rbc_reset_boot dut (.mclk, .rst_b, .boot_mode, .port_select, .big_endian, .test_reset_b,
      .emulation_config_pin_high, .emulation_config_pin_low, .emu_attached, .emu_reset,
      .host_set_int, .core_clear_int, .pwrd_req, .emu_exec_cmd, .emu_pc_write, .core_stall,
      .core_start_pc, .periph_run, .host_port_sel, .pci_sel, .host_mem_access,
      .host_to_core_interrupt_bit, .core_int_pending, .rom_rd_req, .rom_rd_addr, .rom_rd_data,
      .rom_rd_valid, .mem_wr_en, .mem_wr_addr, .mem_wr_data, .copy_done, .pwrd_eff,
      .emu_spin_idle, .pc_write_fail, .emu_cfg, .emu_cfg_valid, .id_variant);
   rbc_rom_model rom (.mclk, .rst_b, .lat, .rom_rd_req, .rom_rd_addr, .rom_rd_data, .rom_rd_valid);
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic results();
      if (fails == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask
   // device reset for 4 cycles, then two edges for the boot choice to settle
   task automatic boot(input logic [1:0] mode, input logic ps, input logic be);
      @(negedge mclk);
      rst_b = 1'b0;
      boot_mode = mode;
      port_select = ps;
      big_endian = be;
      cyc(4);
      chk(core_stall, 1'b1);
      chk(id_variant, 2'h0);
      rst_b = 1'b1;
      cyc(2);
      boot_mode = ~mode; // late change must not alter the running boot
   endtask
   task automatic t_none();
      boot(BOOT_NONE, 1'b0, 1'b0);
      chk(core_stall, 1'b0);
      chk(core_start_pc, CORE_START_PC);
      chk(rom_rd_req, 1'b0);
      chk(id_variant, VARIANT_CODE);
      chk(emu_cfg_valid, 1'b0);
   endtask
   task automatic t_host(input logic ps);
      boot(BOOT_HOST, ps, 1'b0);
      cyc(3);
      chk(core_stall, 1'b1);
      chk(periph_run, 1'b1);
      chk({host_port_sel, pci_sel}, {~ps, ps});
      chk(host_mem_access, 1'b1);
      host_set_int = 1'b1;
      cyc(1);
      host_set_int = 1'b0;
      chk(core_stall, 1'b0);
      chk(core_start_pc, CORE_START_PC);
      chk(host_to_core_interrupt_bit, 1'b1);
      chk(core_int_pending, 1'b0);
      host_set_int = 1'b1;
      cyc(1);
      chk(core_int_pending, 1'b0);
      host_set_int = 1'b0;
      core_clear_int = 1'b1;
      cyc(1);
      core_clear_int = 1'b0;
      chk(host_to_core_interrupt_bit, 1'b0);
      host_set_int = 1'b1;
      cyc(1);
      host_set_int = 1'b0;
      chk(core_int_pending, 1'b1);
   endtask
   // full image copy; the host bit pulsed early must not free the core
   task automatic t_rom(input logic be);
      int w;
      int n;
      logic [31:0] exp;
      w = 0;
      boot(BOOT_ROM, 1'b0, be);
      host_set_int = 1'b1;
      cyc(1);
      host_set_int = 1'b0;
      for (n = 0; n < 20000 && w < ROM_WORDS; n++) begin
         cyc(1);
         chk(core_stall, (mem_wr_en === 1'b1 && w == ROM_WORDS - 1) ? 1'b0 : 1'b1);
         if (mem_wr_en === 1'b1) begin
            for (int k = 0; k < 4; k++) begin
               exp[8 * (be ? 3 - k : k) +: 8] = 8'(ROM_SRC_BASE + 4 * w + k) ^ 8'h5A;
            end
            chk(mem_wr_addr, COPY_DST_BASE + 4 * w);
            chk(mem_wr_data, exp);
            w++;
         end
      end
      if (n >= 20000) begin
         fails++;
         results();
      end
      cyc(2);
      chk(copy_done, 1'b1);
      chk(core_stall, 1'b0);
   endtask
   task automatic t_pwr(input logic [5:0] code);
      boot(BOOT_NONE, 1'b0, 1'b0);
      emu_attached = 1'b1;
      pwrd_req = code;
      cyc(2);
      chk(pwrd_eff, 6'h00);
      emu_reset = 1'b1;
      cyc(2);
      chk(pwrd_eff, code);
      emu_exec_cmd = 1'b1;
      emu_pc_write = 1'b1;
      pwrd_req = 6'h00;
      cyc(2);
      chk(emu_spin_idle, 1'b1);
      chk(pc_write_fail, 1'b1);
      boot(BOOT_NONE, 1'b0, 1'b0);
      chk(emu_spin_idle, 1'b0);
      chk(pc_write_fail, 1'b0);
      emu_attached = 1'b0;
      emu_reset = 1'b0;
      emu_exec_cmd = 1'b0;
      emu_pc_write = 1'b0;
   endtask
   // pins latch only on the test reset rising edge after device release
   task automatic t_emu();
      boot(BOOT_NONE, 1'b0, 1'b0);
      emulation_config_pin_high = 1'b1;
      cyc(3);
      chk(emu_cfg_valid, 1'b0);
      test_reset_b = 1'b1; // clock keeps running through the test reset
      cyc(5);
      chk(emu_cfg, 2'h2);
      chk(emu_cfg_valid, 1'b1);
      emulation_config_pin_high = 1'b0;
      emulation_config_pin_low = 1'b1;
      cyc(5);
      chk(emu_cfg, 2'h2);
      test_reset_b = 1'b0;
      cyc(5);
      chk(emu_cfg_valid, 1'b0);
   endtask
   initial begin
      t_none();
      t_host(1'b0);
      t_host(1'b1);
      t_rom(1'b0);
      lat = 2'h2;
      t_rom(1'b1);
      t_pwr(PWRD_CLOCK_HALT);
      t_pwr(PWRD_OSC_STOP);
      t_emu();
      results();
   end
endmodule
